// File: mcr_pkg.sv
// Constants for the metering configuration and interrupt register bank.
// Assumes a 40 MHz reference clock and a host-driven serial clock.
package mcr_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_OPERATING_CONFIG    = 6'h0a;
  localparam logic [5:0] ADDR_MEAS_CHANNEL_SELECT = 6'h0b;
  localparam logic [5:0] ADDR_WAVEFORM_CONFIG     = 6'h0c;
  localparam logic [5:0] ADDR_ACTIVE_FORMULA      = 6'h0d;
  localparam logic [5:0] ADDR_APPARENT_FORMULA    = 6'h0e;
  localparam logic [5:0] ADDR_INTERRUPT_ENABLE    = 6'h0f;
  localparam logic [5:0] ADDR_INTERRUPT_FLAGS     = 6'h10;
  localparam logic [5:0] ADDR_FLAGS_CLEAR_ON_READ = 6'h11;
  localparam logic [5:0] ADDR_ZERO_CROSS_TIMEOUT  = 6'h12;
  localparam logic [5:0] ADDR_HALF_CYCLE_COUNT    = 6'h13;
  localparam logic [5:0] ADDR_SAG_HALF_CYCLES     = 6'h14;
  localparam logic [5:0] ADDR_SAG_THRESHOLD       = 6'h15;
  localparam logic [5:0] ADDR_VOLTAGE_PEAK_LEVEL  = 6'h16;
  localparam logic [5:0] ADDR_CURRENT_PEAK_LEVEL  = 6'h17;
  localparam logic [5:0] ADDR_AMP_GAIN_CONFIG     = 6'h18;
  localparam logic [5:0] ADDR_PHASE_A_GAIN        = 6'h19;
  localparam logic [5:0] ADDR_PHASE_B_GAIN        = 6'h1a;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_OPERATING_CONFIG    = 8'h04;
  localparam logic [7:0]  RST_MEAS_CHANNEL_SELECT = 8'h70;
  localparam logic [7:0]  RST_WAVEFORM_CONFIG     = 8'h00;
  localparam logic [7:0]  RST_FORMULA             = 8'h3f;
  localparam logic [15:0] RST_INTERRUPT_ENABLE    = 16'h0000;
  localparam logic [15:0] RST_FLAGS               = 16'h0000;
  localparam logic [15:0] RST_ZERO_CROSS_TIMEOUT  = 16'hffff;
  localparam logic [15:0] RST_HALF_CYCLE_COUNT    = 16'hffff;
  localparam logic [7:0]  RST_SAG_HALF_CYCLES     = 8'hff;
  localparam logic [7:0]  RST_SAG_THRESHOLD       = 8'h00;
  localparam logic [7:0]  RST_PEAK_LEVEL          = 8'hff;
  localparam logic [7:0]  RST_AMP_GAIN_CONFIG     = 8'h00;
  localparam logic [11:0] RST_ACTIVE_GAIN         = 12'h000;

  // ----------------------------------------------------------------
  // Communications byte and frame layout
  // ----------------------------------------------------------------
  localparam int         COMM_WRITE_BIT  = 7;
  localparam logic [4:0] COMM_LAST_BIT   = 5'h07;
  localparam logic [4:0] DATA_FIRST_BIT  = 5'h08;
  localparam logic [4:0] LAST_BIT_BYTE1  = 5'h0f;
  localparam logic [4:0] LAST_BIT_BYTE2  = 5'h17;
  localparam logic [4:0] FRAME_BIT_LIMIT = 5'h18;

  // ----------------------------------------------------------------
  // Interrupt flag positions
  // ----------------------------------------------------------------
  localparam int FLAG_ZX_TIMEOUT_A = 0;
  localparam int FLAG_SAG_A        = 3;
  localparam int FLAG_VOLTAGE_PEAK = 6;
  localparam int FLAG_CURRENT_PEAK = 7;
  localparam int FLAG_LINE_CYCLE   = 8;
  localparam int FLAG_EXT_FIRST    = 9;
  localparam int EXT_EVENT_COUNT   = 7;
  localparam int PHASES            = 3;

  // ----------------------------------------------------------------
  // Timing: full-scale zero-cross timeout and its step
  // ----------------------------------------------------------------
  localparam longint CLOCK_PERIOD_NS     = 64'd25;
  localparam longint ZX_TIMEOUT_MAX_US   = 64'd2300000;
  localparam longint ZX_TIMEOUT_STEPS    = 64'd65535;
  localparam longint ZX_STEP_NS          = (ZX_TIMEOUT_MAX_US * 64'd1000) / ZX_TIMEOUT_STEPS;
  localparam longint ZX_STEP_CYCLES_L    = ZX_STEP_NS / CLOCK_PERIOD_NS;
  localparam int     ZX_STEP_CYCLES      = int'((ZX_STEP_CYCLES_L < 64'd1) ? 64'd1 : ZX_STEP_CYCLES_L);

  // Last frame bit for a register: 8-bit registers take one data byte
  function automatic logic [4:0] mcr_last_bit(input logic [5:0] addr);
    logic [4:0] r;
    r = LAST_BIT_BYTE1;
    if (addr == ADDR_INTERRUPT_ENABLE || addr == ADDR_INTERRUPT_FLAGS ||
        addr == ADDR_FLAGS_CLEAR_ON_READ || addr == ADDR_ZERO_CROSS_TIMEOUT ||
        addr == ADDR_HALF_CYCLE_COUNT || addr == ADDR_PHASE_A_GAIN ||
        addr == ADDR_PHASE_B_GAIN) begin
      r = LAST_BIT_BYTE2;
    end
    return r;
  endfunction

endpackage

// File: mcr_regs.sv
// Configuration, interrupt and event-threshold register bank of a metering chip.
// Assumes the serial host changes din on falling sclk edges and waits after the command byte.
//
// Behaviour
// (RL1) Operating config at 0Ah, 8-bit read/write, resets to 4.
// (RL2) Channel select at 0Bh, resets 70h, picks phase for line-cycle and peaks.
// (RL3) Waveform config at 0Ch, resets 0, picks sample source and rate.
// (RL4) Active energy formula register at 0Dh, resets 3Fh.
// (RL5) Apparent energy formula register at 0Eh, resets 3Fh.
// (RL6) Interrupt output low only for events whose enable bit is set.
// (RL7) Read-only 16-bit flag register at 10h, cleared at reset.
// (RL8) Flag view at 11h returns flags then clears them, keeping events raised in the clearing cycle.
// (RL9) Missing zero crossing within programmed timeout raises that line's flag.
// (RL10) Line-cycle accumulation spans programmed number of half line cycles.
// (RL11) Sag declared after programmed consecutive low half cycles, count shared.
// (RL12) One shared 8-bit sag threshold for all three phases.
// (RL13) Voltage peak flag set when selected phase exceeds voltage level.
// (RL14) Current peak flag set when selected phase exceeds current level.
// (RL15) Gain register drives amplifier gain, no-load threshold and absolute summing.
// (RL16) Per-phase 12-bit active power gain registers; only phases A and B (19h, 1Ah) are implemented.
// (RL17) Command byte low six bits address the following data transfer.
// (RL18) Command bit 7 one means write, zero means read.
// (RL19) Host writes to the flag registers are ignored.
`timescale 1ns/10ps
module mcr_regs #(
  parameter int ZX_STEP = mcr_pkg::ZX_STEP_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  output logic             irq_n,
  output logic             irq_oe,
  input  wire logic [2:0]  zero_cross,
  input  wire logic [2:0]  half_cycle_strobe,
  input  wire logic [23:0] half_cycle_level,
  input  wire logic        sample_strobe,
  input  wire logic [23:0] voltage_mag,
  input  wire logic [23:0] current_mag,
  input  wire logic [6:0]  ext_event,
  output logic             line_cycle_done,
  output logic [7:0]       operating_config,
  output logic [7:0]       measurement_channel_select,
  output logic [7:0]       waveform_sampling_config,
  output logic [7:0]       active_energy_formula,
  output logic [7:0]       apparent_energy_formula,
  output logic [15:0]      zero_cross_timeout,
  output logic [15:0]      half_cycle_accum_count,
  output logic [7:0]       amplifier_gain_config,
  output logic [11:0]      phase_a_active_gain,
  output logic [11:0]      phase_b_active_gain
);
  import mcr_pkg::*;

  // ----------------------------------------------------------------
  // Serial link domain
  // ----------------------------------------------------------------
  logic        spi_rst_n;
  logic [4:0]  bit_cnt;
  logic [15:0] shreg;
  logic        comm_write;
  logic [5:0]  comm_addr;
  logic [5:0]  rd_addr;
  logic        rd_tgl;
  logic [5:0]  wr_addr;
  logic [15:0] wr_data;
  logic        wr_tgl;
  logic [15:0] rd_word;
  logic [4:0]  out_idx;

  // Frame logic is cleared whenever chip select is released
  assign spi_rst_n = rstn & ~cs_n;
  assign out_idx   = 5'(bit_cnt - DATA_FIRST_BIT);

  // Bit counter, shifter and command byte capture
  always_ff @(posedge sclk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      bit_cnt    <= 5'h00;
      shreg      <= 16'h0000;
      comm_write <= 1'b0;
      comm_addr  <= 6'h00;
    end else begin
      if (bit_cnt != FRAME_BIT_LIMIT) begin
        bit_cnt <= 5'(bit_cnt + 5'h01);
      end
      shreg <= {shreg[14:0], din};
      if (bit_cnt == COMM_LAST_BIT) begin
        comm_write <= shreg[COMM_WRITE_BIT - 1];   // see (RL18)
        comm_addr  <= {shreg[4:0], din};           // see (RL17)
      end
    end
  end

  // Hand-off words and toggles, kept across frames
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      rd_addr <= 6'h00;
      rd_tgl  <= 1'b0;
      wr_addr <= 6'h00;
      wr_data <= 16'h0000;
      wr_tgl  <= 1'b0;
    end else if (!cs_n) begin
      if (bit_cnt == COMM_LAST_BIT && !shreg[COMM_WRITE_BIT - 1]) begin
        rd_addr <= {shreg[4:0], din};   // see (RL17)
        rd_tgl  <= ~rd_tgl;             // see (RL18)
      end
      if (bit_cnt > COMM_LAST_BIT && comm_write && bit_cnt == mcr_last_bit(comm_addr)) begin
        wr_addr <= comm_addr;           // see (RL17)
        wr_data <= {shreg[14:0], din};
        wr_tgl  <= ~wr_tgl;
      end
    end
  end

  // Read data shifted out on falling edges, MSB first
  always_ff @(negedge sclk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      dout    <= 1'b0;
      dout_oe <= 1'b0;
    end else if (bit_cnt >= DATA_FIRST_BIT && bit_cnt != FRAME_BIT_LIMIT && !comm_write) begin
      dout_oe <= 1'b1;
      dout    <= rd_word[4'hf - out_idx[3:0]];
    end else begin
      dout_oe <= 1'b0;
      dout    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Crossing into the reference domain
  // ----------------------------------------------------------------
  logic [2:0] wr_sync;
  logic [2:0] rd_sync;
  logic       wr_pulse;
  logic       rd_pulse;

  // Two-stage synchronisers plus an edge stage
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_sync <= 3'h0;
      rd_sync <= 3'h0;
    end else begin
      wr_sync <= {wr_sync[1:0], wr_tgl};
      rd_sync <= {rd_sync[1:0], rd_tgl};
    end
  end

  assign wr_pulse = wr_sync[1] ^ wr_sync[2];
  assign rd_pulse = rd_sync[1] ^ rd_sync[2];

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [15:0] interrupt_enable;
  logic [7:0]  sag_half_cycle_count;
  logic [7:0]  sag_threshold;
  logic [7:0]  voltage_peak_level;
  logic [7:0]  current_peak_level;

  // Host writes, unmapped and flag addresses ignored
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      operating_config           <= RST_OPERATING_CONFIG;     // see (RL1)
      measurement_channel_select <= RST_MEAS_CHANNEL_SELECT;  // see (RL2)
      waveform_sampling_config   <= RST_WAVEFORM_CONFIG;      // see (RL3)
      active_energy_formula      <= RST_FORMULA;              // see (RL4)
      apparent_energy_formula    <= RST_FORMULA;              // see (RL5)
      interrupt_enable           <= RST_INTERRUPT_ENABLE;
      zero_cross_timeout         <= RST_ZERO_CROSS_TIMEOUT;
      half_cycle_accum_count     <= RST_HALF_CYCLE_COUNT;
      sag_half_cycle_count       <= RST_SAG_HALF_CYCLES;
      sag_threshold              <= RST_SAG_THRESHOLD;
      voltage_peak_level         <= RST_PEAK_LEVEL;
      current_peak_level         <= RST_PEAK_LEVEL;
      amplifier_gain_config      <= RST_AMP_GAIN_CONFIG;      // see (RL15)
      phase_a_active_gain        <= RST_ACTIVE_GAIN;          // see (RL16)
      phase_b_active_gain        <= RST_ACTIVE_GAIN;
    end else if (wr_pulse) begin
      case (wr_addr)
        ADDR_OPERATING_CONFIG:    operating_config           <= wr_data[7:0];
        ADDR_MEAS_CHANNEL_SELECT: measurement_channel_select <= wr_data[7:0];
        ADDR_WAVEFORM_CONFIG:     waveform_sampling_config   <= wr_data[7:0];
        ADDR_ACTIVE_FORMULA:      active_energy_formula      <= wr_data[7:0];
        ADDR_APPARENT_FORMULA:    apparent_energy_formula    <= wr_data[7:0];
        ADDR_INTERRUPT_ENABLE:    interrupt_enable           <= wr_data;
        ADDR_ZERO_CROSS_TIMEOUT:  zero_cross_timeout         <= wr_data;
        ADDR_HALF_CYCLE_COUNT:    half_cycle_accum_count     <= wr_data;
        ADDR_SAG_HALF_CYCLES:     sag_half_cycle_count       <= wr_data[7:0];
        ADDR_SAG_THRESHOLD:       sag_threshold              <= wr_data[7:0];
        ADDR_VOLTAGE_PEAK_LEVEL:  voltage_peak_level         <= wr_data[7:0];
        ADDR_CURRENT_PEAK_LEVEL:  current_peak_level         <= wr_data[7:0];
        ADDR_AMP_GAIN_CONFIG:     amplifier_gain_config      <= wr_data[7:0];
        ADDR_PHASE_A_GAIN:        phase_a_active_gain        <= wr_data[11:0];
        ADDR_PHASE_B_GAIN:        phase_b_active_gain        <= wr_data[11:0];
        default: ;  // Flags are not writable, see (RL19)
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  logic [15:0] events;
  logic [2:0]  zx_expired;
  logic [2:0]  sag_hit;
  logic [$clog2(ZX_STEP + 1)-1:0] step_cnt;
  logic        step_tick;
  logic [1:0]  phase_sel;
  logic [7:0]  v_sel;
  logic [7:0]  i_sel;
  logic [15:0] half_cnt;
  logic        line_done_evt;

  // Timeout step prescaler
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      step_cnt  <= '0;
      step_tick <= 1'b0;
    end else if (step_cnt == $bits(step_cnt)'(ZX_STEP - 1)) begin
      step_cnt  <= '0;
      step_tick <= 1'b1;
    end else begin
      step_cnt  <= $bits(step_cnt)'(step_cnt + 1'b1);
      step_tick <= 1'b0;
    end
  end

  // Per-phase zero-cross watchdogs and sag counters
  for (genvar p = 0; p < PHASES; p++) begin : g_phase
    logic [15:0] zx_cnt;
    logic [7:0]  sag_cnt;

    // Watchdog reloads on each crossing, fires once on expiry
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        zx_cnt <= RST_ZERO_CROSS_TIMEOUT;
      end else if (zero_cross[p]) begin
        zx_cnt <= zero_cross_timeout;
      end else if (step_tick && zx_cnt != 16'h0000) begin
        zx_cnt <= 16'(zx_cnt - 16'h0001);
      end
    end
    assign zx_expired[p] = step_tick && zx_cnt == 16'h0001 && !zero_cross[p];  // see (RL9)

    // Consecutive low half cycles, saturating at the sag count
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        sag_cnt <= 8'h00;
      end else if (half_cycle_strobe[p]) begin
        if (half_cycle_level[p*8 +: 8] < sag_threshold) begin    // see (RL12)
          if (sag_cnt != sag_half_cycle_count) begin
            sag_cnt <= 8'(sag_cnt + 8'h01);
          end
        end else begin
          sag_cnt <= 8'h00;
        end
      end
    end
    assign sag_hit[p] = half_cycle_strobe[p] && half_cycle_level[p*8 +: 8] < sag_threshold &&
                        8'(sag_cnt + 8'h01) == sag_half_cycle_count;  // see (RL11)
  end

  // Phase chosen for peak and line-cycle measurement
  assign phase_sel = measurement_channel_select[1:0];
  always_comb begin
    unique case (phase_sel)
      2'h1:    begin v_sel = voltage_mag[15:8];  i_sel = current_mag[15:8];  end
      2'h2:    begin v_sel = voltage_mag[23:16]; i_sel = current_mag[23:16]; end
      default: begin v_sel = voltage_mag[7:0];   i_sel = current_mag[7:0];   end
    endcase
  end

  // Half-cycle counter for line-cycle accumulation
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      half_cnt        <= 16'h0000;
      line_cycle_done <= 1'b0;
    end else begin
      line_cycle_done <= line_done_evt;
      if (line_done_evt) begin
        half_cnt <= 16'h0000;
      end else if (zero_cross[phase_sel == 2'h3 ? 2'h0 : phase_sel]) begin
        half_cnt <= 16'(half_cnt + 16'h0001);
      end
    end
  end
  assign line_done_evt = zero_cross[phase_sel == 2'h3 ? 2'h0 : phase_sel] &&
                         16'(half_cnt + 16'h0001) >= half_cycle_accum_count;  // see (RL10)

  // Collected event vector
  always_comb begin
    events = 16'h0000;
    events[FLAG_ZX_TIMEOUT_A +: PHASES] = zx_expired;
    events[FLAG_SAG_A +: PHASES]        = sag_hit;
    events[FLAG_VOLTAGE_PEAK] = sample_strobe && v_sel > voltage_peak_level;  // see (RL13)
    events[FLAG_CURRENT_PEAK] = sample_strobe && i_sel > current_peak_level;  // see (RL14)
    events[FLAG_LINE_CYCLE]   = line_done_evt;
    events[FLAG_EXT_FIRST +: EXT_EVENT_COUNT] = ext_event;
  end

  // ----------------------------------------------------------------
  // Flags, read path and interrupt pin
  // ----------------------------------------------------------------
  logic [15:0] flags;
  logic [15:0] read_val;
  logic        clear_on_read;

  assign clear_on_read = rd_pulse && rd_addr == ADDR_FLAGS_CLEAR_ON_READ;

  // Sticky flags; a new event wins over the read clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flags <= RST_FLAGS;                               // see (RL7)
    end else if (clear_on_read) begin
      flags <= events;                                  // see (RL8)
    end else begin
      flags <= flags | events;                          // see (RL7)
    end
  end

  // Read multiplexer, unmapped addresses read zero
  always_comb begin
    unique case (rd_addr)
      ADDR_OPERATING_CONFIG:    read_val = {operating_config, 8'h00};
      ADDR_MEAS_CHANNEL_SELECT: read_val = {measurement_channel_select, 8'h00};
      ADDR_WAVEFORM_CONFIG:     read_val = {waveform_sampling_config, 8'h00};
      ADDR_ACTIVE_FORMULA:      read_val = {active_energy_formula, 8'h00};
      ADDR_APPARENT_FORMULA:    read_val = {apparent_energy_formula, 8'h00};
      ADDR_INTERRUPT_ENABLE:    read_val = interrupt_enable;
      ADDR_INTERRUPT_FLAGS:     read_val = flags;
      ADDR_FLAGS_CLEAR_ON_READ: read_val = flags;
      ADDR_ZERO_CROSS_TIMEOUT:  read_val = zero_cross_timeout;
      ADDR_HALF_CYCLE_COUNT:    read_val = half_cycle_accum_count;
      ADDR_SAG_HALF_CYCLES:     read_val = {sag_half_cycle_count, 8'h00};
      ADDR_SAG_THRESHOLD:       read_val = {sag_threshold, 8'h00};
      ADDR_VOLTAGE_PEAK_LEVEL:  read_val = {voltage_peak_level, 8'h00};
      ADDR_CURRENT_PEAK_LEVEL:  read_val = {current_peak_level, 8'h00};
      ADDR_AMP_GAIN_CONFIG:     read_val = {amplifier_gain_config, 8'h00};
      ADDR_PHASE_A_GAIN:        read_val = {4'h0, phase_a_active_gain};
      ADDR_PHASE_B_GAIN:        read_val = {4'h0, phase_b_active_gain};
      default:                  read_val = 16'h0000;
    endcase
  end

  // Read word held steady for the link side until the next read
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_word <= 16'h0000;
    end else if (rd_pulse) begin
      rd_word <= read_val;
    end
  end

  // Open-drain interrupt: drive low while an enabled flag is set
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_n  <= 1'b1;
      irq_oe <= 1'b0;
    end else begin
      irq_n  <= ~|(flags & interrupt_enable);           // see (RL6)
      irq_oe <= |(flags & interrupt_enable);
    end
  end

endmodule

// File: mcr_regs_chk.sv
// Assertion checker for the metering register bank.
// Sees only top-level ports; attached by the bind at the foot.
`timescale 1ns/10ps
module mcr_regs_chk #(
  parameter int ZX_STEP = 2
) (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        cs_n,
  input wire logic        dout_oe,
  input wire logic        irq_n,
  input wire logic        irq_oe,
  input wire logic [2:0]  zero_cross,
  input wire logic [2:0]  half_cycle_strobe,
  input wire logic        line_cycle_done,
  input wire logic [7:0]  operating_config,
  input wire logic [7:0]  measurement_channel_select,
  input wire logic [7:0]  active_energy_formula,
  input wire logic [15:0] zero_cross_timeout,
  input wire logic [11:0] phase_a_active_gain
);
  // ----------------------------------------------------------------
  // Properties on the reference clock
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_rst_a; $rose(rstn) |-> operating_config == 8'h04 && measurement_channel_select == 8'h70; endproperty
  a_rst_a: assert property (p_rst_a) else $error("config reset values wrong");
  property p_rst_b;
    $rose(rstn) |-> active_energy_formula == 8'h3f && zero_cross_timeout == 16'hffff && phase_a_active_gain == 12'h000;
  endproperty
  a_rst_b: assert property (p_rst_b) else $error("formula timeout gain reset wrong");
  property p_rst_irq; $rose(rstn) |-> irq_n && !irq_oe; endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("interrupt active after reset");
  property p_irq_oe; irq_oe == !irq_n; endproperty
  a_irq_oe: assert property (p_irq_oe) else $error("interrupt enable mismatch");
  property p_quiet; cs_n [*2] |-> !dout_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("dout driven outside frame");
  property p_stable; cs_n [*8] |=> $stable(operating_config) && $stable(zero_cross_timeout); endproperty
  a_stable: assert property (p_stable) else $error("register changed without frame");
  property p_lcd_one; line_cycle_done |=> !line_cycle_done; endproperty
  a_lcd_one: assert property (p_lcd_one) else $error("line cycle pulse too long");
  property p_lcd_cause; line_cycle_done |-> $past(zero_cross) != 3'h0 || $past(half_cycle_strobe) != 3'h0; endproperty
  a_lcd_cause: assert property (p_lcd_cause) else $error("line cycle pulse without crossing");
endmodule
bind mcr_regs mcr_regs_chk #(.ZX_STEP(ZX_STEP)) chk (.ref_clk(ref_clk), .rstn(rstn), .cs_n(cs_n),
  .dout_oe(dout_oe), .irq_n(irq_n), .irq_oe(irq_oe), .zero_cross(zero_cross),
  .half_cycle_strobe(half_cycle_strobe), .line_cycle_done(line_cycle_done), .operating_config(operating_config),
  .measurement_channel_select(measurement_channel_select), .active_energy_formula(active_energy_formula),
  .zero_cross_timeout(zero_cross_timeout), .phase_a_active_gain(phase_a_active_gain));

// File: mcr_host.sv
// Serial host model: frames of command byte plus data, 48 ns link clock.
// Assumes the device samples din on rising and shifts dout on falling edges.
`timescale 1ns/10ps
module mcr_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  // Link idle: clock stands low, select high
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // One frame; read bits gathered on rising edges
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int nb, output logic [15:0] rd);
    rd = 16'h0000;
    #3 cs_n = 1'b0;
    for (int k = 0; k < 8 + nb; k++) begin
      din = (k < 8) ? cmd[7-k] : wd[nb-1-(k-8)];
      #24 sclk = 1'b1;
      if (k >= 8) rd = {rd[14:0], dout};
      #24;
      if (k == 7 && !cmd[7]) #200; // Read word hand-off pause
      sclk = 1'b0;
    end
    #24 cs_n = 1'b1;
    din = ~din; // Released line shows no stale bit
    #250;
  endtask
endmodule

// File: test_mcr_regs.sv
// Self-checking bench for the register bank, host model on the link.
// Assumes the bound checker and a shortened zero-cross step.
`timescale 1ns/10ps
module test_mcr_regs;
  `define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", n, e, s); end end
  logic        ref_clk = 1'b0, rstn = 1'b0, sclk, cs_n, din, dout, irq_n, line_cycle_done;
  logic [2:0]  zero_cross = 3'h0;
  logic        sample_strobe = 1'b0;
  logic [23:0] voltage_mag = 24'h0, current_mag = 24'h0;
  logic [6:0]  ext_event = 7'h00;
  logic [7:0]  operating_config;
  logic [15:0] r;
  int          miscompares = 0, tests_run = 0, i, n, zc = 0;
  bit          zx_on = 1'b0;
  logic [5:0]  ra [18] = '{6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14,
                           6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h20};
  logic [15:0] rv [18] = '{16'h4, 16'h70, 16'h0, 16'h3f, 16'h3f, 16'h0, 16'h0, 16'h0, 16'hffff, 16'hffff,
                           16'hff, 16'h0, 16'hff, 16'hff, 16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] wm [18] = '{16'hff, 16'hff, 16'hff, 16'hff, 16'hff, 16'hffff, 16'h0, 16'h0, 16'hffff, 16'hffff,
                           16'hff, 16'hff, 16'hff, 16'hff, 16'hff, 16'hfff, 16'hfff, 16'h0};
  mcr_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  mcr_regs #(.ZX_STEP(2)) uut (.ref_clk(ref_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(), .irq_n(irq_n), .irq_oe(), .zero_cross(zero_cross), .half_cycle_strobe(3'h0),
    .half_cycle_level(24'h0), .sample_strobe(sample_strobe), .voltage_mag(voltage_mag), .current_mag(current_mag),
    .ext_event(ext_event), .line_cycle_done(line_cycle_done), .operating_config(operating_config),
    .measurement_channel_select(), .waveform_sampling_config(), .active_energy_formula(),
    .apparent_energy_formula(), .zero_cross_timeout(), .half_cycle_accum_count(), .amplifier_gain_config(),
    .phase_a_active_gain(), .phase_b_active_gain());
  // Reference clock, 25 ns
  always #12.5 ref_clk = ~ref_clk;
  // All three phases cross every 40 cycles while enabled
  always @(negedge ref_clk) begin
    zc <= (zc == 39) ? 0 : zc + 1;
    zero_cross <= (zx_on && zc == 0) ? 3'h7 : 3'h0;
  end
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [5:0] a, input logic [15:0] d, input int nb);
    host.xfer({2'b10, a}, d, nb, r);
  endtask
  task automatic rd(input logic [5:0] a, input int nb, input logic [15:0] m, input logic [15:0] e);
    host.xfer({2'b00, a}, 16'h0000, nb, r);
    `CHK("register", e, r & m)
  endtask
  task automatic ev(input logic [6:0] v);
    @(negedge ref_clk) ext_event = v;
    @(negedge ref_clk) ext_event = 7'h00;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    for (i = 0; i < 18; i++) rd(ra[i], wm[i] == 16'hff ? 8 : 16, 16'hffff, rv[i]);
    wr(6'h13, 16'h0004, 16);
    zx_on = 1'b1;
    for (n = 0; n < 400 && !line_cycle_done; n++) @(negedge ref_clk);
    @(negedge ref_clk);
    for (n = 1; n < 400 && !line_cycle_done; n++) @(negedge ref_clk);
    `CHK("line_cycle_gap", 160, n)
    for (i = 0; i < 18; i++) wr(ra[i], 16'hc35a ^ 16'(i << 4), wm[i] == 16'hff ? 8 : 16);
    for (i = 0; i < 18; i++) rd(ra[i], wm[i] == 16'hff ? 8 : 16, ra[i][5:1] == 5'h08 ? 16'hfe00 : 16'hffff, (16'hc35a ^ 16'(i << 4)) & wm[i]);
    `CHK("operating_config", 8'h5a, operating_config)
    wr(6'h0f, 16'h0200, 16);
    ev(7'h02);
    repeat (4) @(negedge ref_clk);
    `CHK("irq_n", 1'b1, irq_n)
    rd(6'h10, 16, 16'hfe07, 16'h0400);
    ev(7'h01);
    repeat (4) @(negedge ref_clk);
    `CHK("irq_n", 1'b0, irq_n)
    rd(6'h11, 16, 16'hfe07, 16'h0600);
    rd(6'h10, 16, 16'hfe07, 16'h0000);
    `CHK("irq_n", 1'b1, irq_n)
    wr(6'h16, 16'h0080, 8);
    wr(6'h17, 16'h00f0, 8);
    @(negedge ref_clk) {sample_strobe, voltage_mag, current_mag} = {1'b1, 24'h909090, 24'h101010};
    @(negedge ref_clk) sample_strobe = 1'b0;
    rd(6'h10, 16, 16'h00c0, 16'h0040);
    wr(6'h12, 16'h0003, 16);
    repeat (100) @(negedge ref_clk);
    rd(6'h10, 16, 16'h0007, 16'h0007);
    tally_and_finish();
  end
endmodule
